// *** hw/bmc_pkg.sv ***
// package: bus matrix configuration register map and field layout
package bmc_pkg;
  localparam logic [11:0] BMC_OFS_CONFIG = 12'h000;
  localparam logic [11:0] BMC_OFS_KERNEL_BASE = 12'h010;
  localparam logic [11:0] BMC_OFS_USER_BASE = 12'h020;
  localparam logic [11:0] BMC_OFS_RAM_SIZE = 12'h040;
  localparam logic [11:0] BMC_OFS_DEBUG_STATUS = 12'h080;
  localparam logic [1:0] BMC_SUB_WRITE = 2'h0;
  localparam logic [1:0] BMC_SUB_CLEAR = 2'h1;
  localparam logic [1:0] BMC_SUB_SET = 2'h2;
  localparam logic [1:0] BMC_SUB_INVERT = 2'h3;
  localparam int BMC_BIT_SHARED = 20;
  localparam int BMC_BIT_DEBUG = 19;
  localparam int BMC_BIT_DMA = 18;
  localparam int BMC_BIT_CPU_DATA = 17;
  localparam int BMC_BIT_CPU_INSTR = 16;
  localparam int BMC_BIT_WAIT = 6;
  localparam int BMC_ARB_LSB = 0;
  localparam int BMC_ARB_W = 3;
  localparam logic [31:0] BMC_CONFIG_MASK = 32'h001f_0047;
  localparam logic [31:0] BMC_CONFIG_RESET = 32'h001f_0041;
  localparam logic [31:0] BMC_BASE_MASK = 32'h0000_fc00;
  localparam logic [31:0] BMC_BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] BMC_RAM_SIZE_DEFAULT = 32'h0001_0000;
  localparam logic [1:0] BMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BMC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    BMC_ARB_MODE0 = 2'h0,
    BMC_ARB_MODE1 = 2'h1,
    BMC_ARB_MODE2 = 2'h2,
    BMC_ARB_RSVD = 2'h3
  } bmc_arb_t;
endpackage

// *** hw/bmc_err_gate.sv ***
// one initiator's unmapped-access error gate
`timescale 1ns/1ps
module bmc_err_gate (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic enable, // error enable bit
  input wire logic suppress, // debug-mode suppression
  input wire logic unmapped, // unmapped access strobe
  output logic bus_error // registered exception pulse
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_error <= 1'b0;
    end else begin
      bus_error <= unmapped & enable & ~suppress;
    end
  end
endmodule

// *** hw/bmc_top.sv ***
// bus matrix configuration block with axi4-lite register slave
`timescale 1ns/1ps
module bmc_top import bmc_pkg::*; #(
  parameter logic [31:0] RAM_SIZE = BMC_RAM_SIZE_DEFAULT
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic cpu_debug_mode, // processor halted in debug
  input wire logic unmapped_shared_bus, // unmapped access, shared bus
  input wire logic unmapped_debug_unit, // unmapped access, debug unit
  input wire logic unmapped_dma, // unmapped access, dma engine
  input wire logic unmapped_cpu_data, // unmapped cpu data access
  input wire logic unmapped_cpu_instr, // unmapped cpu instruction fetch
  output logic bus_error_shared_bus, // exception, shared bus
  output logic bus_error_debug_unit, // exception, debug unit
  output logic bus_error_dma, // exception, dma engine
  output logic bus_error_cpu_data, // exception, cpu data
  output logic bus_error_cpu_instr, // exception, cpu instruction
  output logic ram_wait_state_select, // one ram setup wait state
  output logic [1:0] arbitration_mode, // decoded arbitration mode
  output logic [15:0] ram_kernel_program_base, // kernel program offset
  output logic [15:0] ram_user_data_base, // user data offset
  output logic [31:0] data_ram_size // static ram capacity, bytes
);
  // ram size grain, and the largest ram that 16-bit bases can split
  localparam int RAM_GRAIN_W = 10;
  localparam logic [31:0] RAM_SIZE_MAX = 32'h0001_0000;

  // byte-address fields: register slot and companion sub-address
  localparam int ADDR_MSB = 11;
  localparam int SLOT_LSB = 4;
  localparam int SUB_LSB = 2;
  localparam int SUB_W = 2;
  localparam int BASE_W = 16;

  // arbitration field codes that select a defined mode
  localparam logic [BMC_ARB_W-1:0] ARB_CODE_MODE0 = 3'h0;
  localparam logic [BMC_ARB_W-1:0] ARB_CODE_MODE1 = 3'h1;
  localparam logic [BMC_ARB_W-1:0] ARB_CODE_MODE2 = 3'h2;

  // refuse ram sizes that the partition bases cannot serve
  if (RAM_SIZE == 32'h0000_0000) begin : g_size_zero
    $error("ram size must be non-zero");
  end
  if (RAM_SIZE[RAM_GRAIN_W-1:0] != {RAM_GRAIN_W{1'b0}}) begin : g_size_grain
    $error("ram size must be a multiple of 1 KB");
  end
  if (RAM_SIZE > RAM_SIZE_MAX) begin : g_size_max
    $error("ram size above what 16-bit bases can reach");
  end

  // reset release through two flops
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  logic [31:0] config_q;
  logic [31:0] kbase_q;
  logic [31:0] ubase_q;

  // write channel capture
  // address and data may come in either order; each waits for the other
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // byte-lane expansion of the write strobes
  logic [31:0] wmask;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wstrb_q[i]}};
    end
  end

  // register decode: base offset plus companion sub-address
  logic [11:0] wbase;
  logic [1:0] wsub;
  logic wr_hit_cfg;
  logic wr_hit_kb;
  logic wr_hit_ub;
  logic wr_ro;
  assign wbase = {awaddr_q[ADDR_MSB:SLOT_LSB], {SLOT_LSB{1'b0}}};
  assign wsub = awaddr_q[SUB_LSB +: SUB_W];
  assign wr_hit_cfg = do_write && wbase == BMC_OFS_CONFIG;
  assign wr_hit_kb = do_write && wbase == BMC_OFS_KERNEL_BASE;
  assign wr_hit_ub = do_write && wbase == BMC_OFS_USER_BASE;
  // read-only slots take writes and ignore them
  assign wr_ro = awaddr_q == BMC_OFS_RAM_SIZE ||
                 awaddr_q == BMC_OFS_DEBUG_STATUS;

  // plain, clear, set or invert update, fixed bits untouched
  function automatic logic [31:0] upd(input logic [31:0] cur,
                                      input logic [1:0] sub,
                                      input logic [31:0] data,
                                      input logic [31:0] lanes,
                                      input logic [31:0] impl);
    logic [31:0] m;
    logic [31:0] nxt;
    m = lanes & impl;
    case (sub)
      BMC_SUB_WRITE: nxt = (cur & ~m) | (data & m);
      BMC_SUB_CLEAR: nxt = cur & ~(data & m);
      BMC_SUB_SET: nxt = cur | (data & m);
      BMC_SUB_INVERT: nxt = cur ^ (data & m);
      default: nxt = cur;
    endcase
    return nxt & impl;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_q <= BMC_CONFIG_RESET;
    end else if (wr_hit_cfg) begin
      config_q <= upd(config_q, wsub, wdata_q, wmask,
                      BMC_CONFIG_MASK);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kbase_q <= BMC_BASE_RESET;
    end else if (wr_hit_kb) begin
      kbase_q <= upd(kbase_q, wsub, wdata_q, wmask,
                     BMC_BASE_MASK);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ubase_q <= BMC_BASE_RESET;
    end else if (wr_hit_ub) begin
      ubase_q <= upd(ubase_q, wsub, wdata_q, wmask,
                     BMC_BASE_MASK);
    end
  end

  // write response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // unmapped slots answer an error and leave every register alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bresp <= BMC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= (wr_hit_cfg || wr_hit_kb || wr_hit_ub || wr_ro) ?
                     BMC_RESP_OKAY : BMC_RESP_SLVERR;
    end
  end

  // read channel; companions read back the register itself
  logic [11:0] rbase;
  logic [31:0] rd_val;
  logic rd_ok;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rbase = {s_axi_araddr[ADDR_MSB:SLOT_LSB], {SLOT_LSB{1'b0}}};
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (rbase == BMC_OFS_CONFIG) begin
      rd_val = config_q;
    end else if (rbase == BMC_OFS_KERNEL_BASE) begin
      rd_val = kbase_q;
    end else if (rbase == BMC_OFS_USER_BASE) begin
      rd_val = ubase_q;
    end else if (s_axi_araddr == BMC_OFS_RAM_SIZE) begin
      rd_val = RAM_SIZE;
    end else if (s_axi_araddr == BMC_OFS_DEBUG_STATUS) begin
      rd_val = {31'h0, cpu_debug_mode};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // read data and response stand with rvalid until rready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= BMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? BMC_RESP_OKAY : BMC_RESP_SLVERR;
    end
  end

  // configuration outputs
  logic [BMC_ARB_W-1:0] arb_code;
  assign arb_code = config_q[BMC_ARB_LSB +: BMC_ARB_W];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arbitration_mode <= BMC_ARB_MODE1;
    end else begin
      case (arb_code)
        ARB_CODE_MODE0: arbitration_mode <= BMC_ARB_MODE0;
        ARB_CODE_MODE1: arbitration_mode <= BMC_ARB_MODE1;
        ARB_CODE_MODE2: arbitration_mode <= BMC_ARB_MODE2;
        // reserved codes read back as written and show as mode 3
        default: arbitration_mode <= BMC_ARB_RSVD;
      endcase
    end
  end

  // registered copies lag their register by one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_wait_state_select <= BMC_CONFIG_RESET[BMC_BIT_WAIT];
    end else begin
      ram_wait_state_select <= config_q[BMC_BIT_WAIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_kernel_program_base <= BMC_BASE_RESET[BASE_W-1:0];
    end else begin
      ram_kernel_program_base <= kbase_q[BASE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_user_data_base <= BMC_BASE_RESET[BASE_W-1:0];
    end else begin
      ram_user_data_base <= ubase_q[BASE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ram_size <= 32'h0000_0000;
    end else begin
      data_ram_size <= RAM_SIZE;
    end
  end

  // per-initiator error gates
  bmc_err_gate u_gate_shared (
    .clk(clk),
    .rst_n(rst_n),
    .enable(config_q[BMC_BIT_SHARED]),
    .suppress(1'b0),
    .unmapped(unmapped_shared_bus),
    .bus_error(bus_error_shared_bus)
  );
  bmc_err_gate u_gate_debug (
    .clk(clk),
    .rst_n(rst_n),
    .enable(config_q[BMC_BIT_DEBUG]),
    .suppress(1'b0),
    .unmapped(unmapped_debug_unit),
    .bus_error(bus_error_debug_unit)
  );
  bmc_err_gate u_gate_dma (
    .clk(clk),
    .rst_n(rst_n),
    .enable(config_q[BMC_BIT_DMA]),
    .suppress(1'b0),
    .unmapped(unmapped_dma),
    .bus_error(bus_error_dma)
  );
  bmc_err_gate u_gate_cpu_data (
    .clk(clk),
    .rst_n(rst_n),
    .enable(config_q[BMC_BIT_CPU_DATA]),
    .suppress(cpu_debug_mode),
    .unmapped(unmapped_cpu_data),
    .bus_error(bus_error_cpu_data)
  );
  bmc_err_gate u_gate_cpu_instr (
    .clk(clk),
    .rst_n(rst_n),
    .enable(config_q[BMC_BIT_CPU_INSTR]),
    .suppress(cpu_debug_mode),
    .unmapped(unmapped_cpu_instr),
    .bus_error(bus_error_cpu_instr)
  );
endmodule

// *** test/bmc_sva.sv ***
// checker: port assertions for the bus matrix configuration block
`timescale 1ns/1ps
module bmc_sva import bmc_pkg::*; #(
  parameter logic [31:0] RAM_SIZE = BMC_RAM_SIZE_DEFAULT
) (
  input wire logic clk, // clock
  input wire logic rst_b, // reset
  input wire logic cpu_debug_mode, // debug
  input wire logic unmapped_shared_bus, // cause
  input wire logic unmapped_debug_unit, // cause
  input wire logic unmapped_dma, // cause
  input wire logic unmapped_cpu_data, // cause
  input wire logic unmapped_cpu_instr, // cause
  input wire logic bus_error_shared_bus, // effect
  input wire logic bus_error_debug_unit, // effect
  input wire logic bus_error_dma, // effect
  input wire logic bus_error_cpu_data, // effect
  input wire logic bus_error_cpu_instr, // effect
  input wire logic ram_wait_state_select, // wait
  input wire logic [1:0] arbitration_mode, // mode
  input wire logic [15:0] ram_kernel_program_base, // base
  input wire logic [15:0] ram_user_data_base, // base
  input wire logic [31:0] data_ram_size // size
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_shared_cause: assert property (
    bus_error_shared_bus |-> $past(unmapped_shared_bus))
    else $error("shared bus error without cause");
  chk_debug_cause: assert property (
    bus_error_debug_unit |-> $past(unmapped_debug_unit))
    else $error("debug unit error without cause");
  chk_dma_cause: assert property (
    bus_error_dma |-> $past(unmapped_dma))
    else $error("dma error without cause");
  chk_data_halted: assert property (
    bus_error_cpu_data |-> $past(unmapped_cpu_data) && !$past(cpu_debug_mode))
    else $error("cpu data error while halted or idle");
  chk_instr_halted: assert property (
    bus_error_cpu_instr |-> $past(unmapped_cpu_instr) && !$past(cpu_debug_mode))
    else $error("cpu instr error while halted or idle");
  chk_base_align: assert property (
    ram_kernel_program_base[9:0] == 10'h0 && ram_user_data_base[9:0] == 10'h0)
    else $error("base not on 1 KB boundary");
  chk_size_static: assert property (
    $past(rst_b, 4) |-> data_ram_size == RAM_SIZE)
    else $error("ram size not static");
  chk_reset_state: assert property (
    !$past(rst_b) |-> ram_wait_state_select && arbitration_mode == 2'h1
      && ram_kernel_program_base == 16'h0 && ram_user_data_base == 16'h0)
    else $error("wrong state leaving reset");
endmodule

bind bmc_top bmc_sva #(.RAM_SIZE(RAM_SIZE)) u_sva (.clk, .rst_b,
  .cpu_debug_mode, .unmapped_shared_bus, .unmapped_debug_unit,
  .unmapped_dma, .unmapped_cpu_data, .unmapped_cpu_instr,
  .bus_error_shared_bus, .bus_error_debug_unit, .bus_error_dma,
  .bus_error_cpu_data, .bus_error_cpu_instr, .ram_wait_state_select,
  .arbitration_mode, .ram_kernel_program_base, .ram_user_data_base,
  .data_ram_size);

// *** test/bmc_initiators.sv ***
// partner: bus initiators raising unmapped accesses and cpu debug state
`timescale 1ns/1ps
module bmc_initiators (
  input wire logic clk, // clock
  input wire logic [4:0] fire, // requested unmapped accesses
  input wire logic halt, // cpu enters debug mode
  output logic [4:0] unmapped, // one strobe per request
  output logic debug_mode // cpu debug state
);
  always @(posedge clk) begin
    unmapped <= fire;
    debug_mode <= halt;
  end
endmodule

// *** test/tb_bmc_top.sv ***
// testbench: bus matrix configuration block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb_bmc_top import bmc_pkg::*;;
  localparam logic [31:0] RSZ = 32'h0000_1000;
  localparam logic [11:0] CF = BMC_OFS_CONFIG;
  localparam logic [11:0] KB = BMC_OFS_KERNEL_BASE;
  localparam logic [11:0] UB = BMC_OFS_USER_BASE;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, halt = 0;
  logic [4:0] fire = 5'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ram_wait_state_select, cpu_debug_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp, arbitration_mode, rsp;
  logic [31:0] s_axi_rdata, data_ram_size, rd;
  logic [15:0] ram_kernel_program_base, ram_user_data_base;
  logic [4:0] um, ex;
  wire [4:0] be;
  int n_fail = 0, compares = 0, cyc = 0;
  bmc_initiators u_init (.clk, .fire, .halt, .unmapped(um),
    .debug_mode(cpu_debug_mode));
  bmc_top #(.RAM_SIZE(RSZ)) dut (.clk, .rst_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cpu_debug_mode, .unmapped_shared_bus(um[4]),
    .unmapped_debug_unit(um[3]), .unmapped_dma(um[2]),
    .unmapped_cpu_data(um[1]), .unmapped_cpu_instr(um[0]),
    .bus_error_shared_bus(be[4]), .bus_error_debug_unit(be[3]),
    .bus_error_dma(be[2]), .bus_error_cpu_data(be[1]),
    .bus_error_cpu_instr(be[0]), .ram_wait_state_select,
    .arbitration_mode, .ram_kernel_program_base, .ram_user_data_base,
    .data_ram_size);
  initial forever #2 clk = ~clk;
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic chk_rd(string n, logic [11:0] a, logic [31:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    `CHK(n, e, rd)
  endtask
  task t_reset;
    chk_rd("config", CF, 32'h001f_0041);
    chk_rd("kbase", KB, 32'h0);
    chk_rd("ubase", UB, 32'h0);
    chk_rd("size", BMC_OFS_RAM_SIZE, RSZ);
    `CHK("wait", 1'b1, ram_wait_state_select)
    `CHK("arb", 2'h1, arbitration_mode)
    `CHK("size_out", RSZ, data_ram_size)
  endtask
  task t_config;
    wr(CF, 32'hffff_fff8);
    chk_rd("config", CF, 32'h001f_0040);
    `CHK("arb", 2'h0, arbitration_mode)
    for (int i = 1; i < 3; i++) begin
      wr(CF, i); // reserved codes never written
      chk_rd("config", CF, i);
      `CHK("arb", i[1:0], arbitration_mode)
      `CHK("wait", 1'b0, ram_wait_state_select)
    end
  endtask
  task t_comp;
    wr(CF + 12'h8, 32'h001f_0040);
    chk_rd("set", CF, 32'h001f_0042);
    wr(CF + 12'h4, 32'h0010_0002);
    chk_rd("clear", CF, 32'h000f_0040);
    wr(CF + 12'hc, 32'h0010_0041);
    chk_rd("invert", CF, 32'h001f_0001);
  endtask
  task t_bases;
    wr(KB, 32'hffff_0bff);
    chk_rd("kbase", KB, 32'h0000_0800);
    wr(UB, 32'hffff_0fff);
    chk_rd("ubase", UB, 32'h0000_0c00);
    `CHK("kout", 16'h0800, ram_kernel_program_base)
    `CHK("uout", 16'h0c00, ram_user_data_base)
    wr(KB + 12'hc, 32'h0000_0c00);
    chk_rd("kinv", KB, 32'h0000_0400);
    wr(BMC_OFS_RAM_SIZE, 32'h0);
    `CHK("ro_bresp", BMC_RESP_OKAY, rsp)
    chk_rd("size", BMC_OFS_RAM_SIZE, RSZ);
    wr(12'h100, 32'h1);
    `CHK("bresp", BMC_RESP_SLVERR, rsp)
    chk_rd("hole", 12'h100, 32'h0);
    `CHK("rresp", BMC_RESP_SLVERR, rsp)
  endtask
  task t_errors;
    for (int i = 0; i < 5; i++)
      for (int en = 0; en < 2; en++)
        for (int dbg = 0; dbg < 2; dbg++) begin
          wr(CF + (en ? 12'h8 : 12'h4), 32'h1 << (16 + i));
          @(posedge clk);
          halt <= dbg[0];
          fire <= 5'h1 << i;
          @(posedge clk);
          fire <= 5'h0;
          repeat (2) @(posedge clk);
          ex = (en && !(dbg && i < 2)) ? 5'h1 << i : 5'h0;
          `CHK("bus_error", ex, be)
        end
    halt <= 1'b0;
  endtask
  task results;
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_config();
    t_comp();
    t_bases();
    t_errors();
    results();
  end
endmodule
